// >>> hw/aap_pkg.sv
package aap_pkg;
    // Word and field layout
    localparam int VA_W          = 16;
    localparam int DISP_W        = 8;
    localparam int SIGN_BIT      = 7;
    localparam int MODE_X_BIT    = 10;
    localparam int MODE_I_BIT    = 9;
    localparam int MODE_B_BIT    = 8;
    localparam int PAGE_OFF_W    = 10;
    localparam int VPN_W         = 6;
    localparam int TAB_SEL_W     = 2;
    localparam int RING_W        = 2;
    // Physical address widths
    localparam int NORM_PA_W     = 19;
    localparam int EXT_PA_W      = 24;
    localparam int NORM_PPN_W    = NORM_PA_W - PAGE_OFF_W;
    localparam int EXT_PPN_W     = EXT_PA_W - PAGE_OFF_W;
    // Protect part of a table entry
    localparam int PROT_W        = 7;
    localparam int PROT_WRITE_B  = 6;
    localparam int PROT_READ_B   = 5;
    localparam int PROT_FETCH_B  = 4;
    localparam int PROT_RING_LSB = 0;
    // Page table storage
    localparam int PT_ADDR_W     = TAB_SEL_W + VPN_W;
    localparam int PT_DATA_W     = PROT_W + EXT_PPN_W;
    // Reset values and steps
    localparam logic [15:0] PC_STEP  = 16'h0001;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    typedef enum logic [1:0] {AAP_CMD_NONE, AAP_CMD_FETCH, AAP_CMD_START, AAP_CMD_EA} aap_cmd_t;
    typedef enum logic [1:0] {AAP_ACC_READ, AAP_ACC_WRITE, AAP_ACC_FETCH} aap_acc_t;
endpackage

// >>> hw/aap_pt_if.sv
`timescale 1ns/100ps
interface aap_pt_if;
    logic                           wr_en;
    logic [aap_pkg::PT_ADDR_W-1:0] wr_addr;
    logic [aap_pkg::PT_DATA_W-1:0] wr_data;
    logic [aap_pkg::PT_ADDR_W-1:0] rd_addr;
    logic [aap_pkg::PT_DATA_W-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> hw/aap_page_table.sv
`timescale 1ns/100ps
module aap_page_table #(
    parameter int ADDR_W = aap_pkg::PT_ADDR_W,
    parameter int DATA_W = aap_pkg::PT_DATA_W
) (
    // Clock
    input wire logic clk_in,
    // Table port
    aap_pt_if.mem    pt
);
    if (ADDR_W != aap_pkg::PT_ADDR_W || DATA_W != aap_pkg::PT_DATA_W) begin : g_chk
        $error("aap_page_table: geometry must match the carrier");
    end

    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

    // Registered read, one cycle after the address
    always_ff @(posedge clk_in) begin
        if (pt.wr_en) begin
            mem_q[pt.wr_addr] <= pt.wr_data;
        end
        pt.rd_data <= mem_q[pt.rd_addr];
    end
endmodule

// >>> hw/aap_core.sv
`timescale 1ns/100ps
// Behaviour
// - Displacement bit 7 copied into bits 8..15 before any addition.
// - Mode from three held word bits; microprogram commands steer every operation.
// - Adder operands: X, B, counter, indirect latch, extended displacement.
// - Fetch selects counter as address and increments it together.
// - After counter change: drop prefetch, fetch at new counter, then prefetch.
// - Starting a prefetched instruction launches prefetch at incremented counter.
// - Counter-relative address is incremented counter minus one plus displacement.
// - Indirect bit set: pointer read first, operand access second.
// - Indirect first cycle: base plus displacement read into indirect latch.
// - Indirect second cycle: latch plus X forms operand address.
// - Normal paging maps 16-bit virtual to 19-bit physical.
// - Extended paging maps 16-bit virtual to 24-bit physical.
// - Pages of 1024 words, each holding data or instructions.
// - Read, write and fetch each blockable per page independently.
// - Every page and user sits on one of four rings.
// - Refuse access when user ring is below page ring.
// - Four page tables with protect and map parts on the data bus.
// - Post-index bit 10, indirect bit 9, pre-index bit 8, displacement 0..7.
// - Virtual bits 10..15 pick one of 64 entries; low ten pass through.
module aap_core (
    // Clock and reset
    input  wire logic                             sys_clk_in,
    input  wire logic                             arst_n_in,
    // Microprogram control
    input  wire aap_pkg::aap_cmd_t                cmd_in,
    input  wire logic                             op_write_in,
    input  wire logic                             pc_load_in,
    input  wire logic [aap_pkg::VA_W-1:0]         pc_new_in,
    // Index and base registers
    input  wire logic [aap_pkg::VA_W-1:0]         x_reg_in,
    input  wire logic [aap_pkg::VA_W-1:0]         b_reg_in,
    // Memory bus
    output logic                                  mem_req_out,
    output aap_pkg::aap_acc_t                     mem_kind_out,
    output logic [aap_pkg::EXT_PA_W-1:0]          mem_paddr_out,
    input  wire logic                             mem_ack_in,
    input  wire logic [aap_pkg::VA_W-1:0]         mem_rdata_in,
    // Paging control
    input  wire logic                             ext_mode_in,
    input  wire logic [aap_pkg::TAB_SEL_W-1:0]    pt_sel_in,
    input  wire logic [aap_pkg::RING_W-1:0]       user_ring_in,
    // Page table load from the internal data bus
    input  wire logic                             pt_wr_in,
    input  wire logic [aap_pkg::TAB_SEL_W-1:0]    pt_wr_tab_in,
    input  wire logic [aap_pkg::VPN_W-1:0]        pt_wr_vpn_in,
    input  wire logic [aap_pkg::PROT_W-1:0]       pt_wr_prot_in,
    input  wire logic [aap_pkg::EXT_PPN_W-1:0]    pt_wr_map_in,
    // Status
    output logic [aap_pkg::VA_W-1:0]              pc_out,
    output logic [aap_pkg::VA_W-1:0]              held_instruction_word_out,
    output logic [aap_pkg::VA_W-1:0]              prefetched_instruction_word_out,
    output logic                                  pf_valid_out,
    output logic [aap_pkg::VA_W-1:0]              indirect_read_latch_out,
    output logic [aap_pkg::VA_W-1:0]              ea_out,
    output logic [aap_pkg::EXT_PA_W-1:0]          ea_paddr_out,
    output logic                                  ea_valid_out,
    output logic                                  fault_out,
    output logic                                  busy_out
);
    typedef enum logic [2:0] {S_IDLE, S_LOOK, S_CHK, S_BUS, S_POST} aap_state_t;
    typedef enum logic [1:0] {U_FETCH, U_PREF, U_PTR, U_OPND} aap_use_t;

    logic [1:0]                        rst_sync_q;
    logic                              rst_n;
    aap_state_t                        st_q;
    aap_use_t                          use_q;
    logic [aap_pkg::VA_W-1:0]          va_q;
    logic [aap_pkg::VA_W-1:0]          pc_q;
    logic [aap_pkg::VA_W-1:0]          held_q;
    logic [aap_pkg::VA_W-1:0]          pf_word_q;
    logic                              pf_valid_q;
    logic [aap_pkg::VA_W-1:0]          ind_latch_q;
    logic [aap_pkg::VA_W-1:0]          ea_q;
    logic [aap_pkg::EXT_PA_W-1:0]      ea_paddr_q;
    logic                              ea_valid_q;
    logic                              fault_q;
    logic                              mem_req_q;
    aap_pkg::aap_acc_t                 mem_kind_q;
    logic [aap_pkg::EXT_PA_W-1:0]      mem_paddr_q;

    logic [aap_pkg::VA_W-1:0]          disp_ext;
    logic [aap_pkg::VA_W-1:0]          base_val;
    logic [aap_pkg::VA_W-1:0]          x_off;
    logic [aap_pkg::VA_W-1:0]          pre_sum;
    logic [aap_pkg::VA_W-1:0]          direct_ea;
    logic                              m_x;
    logic                              m_i;
    logic                              m_b;
    logic [aap_pkg::PROT_W-1:0]        prot;
    logic [aap_pkg::EXT_PPN_W-1:0]     ppn;
    logic [aap_pkg::RING_W-1:0]        page_ring;
    aap_pkg::aap_acc_t                 acc_kind;
    logic                              permit_ok;
    logic                              ring_ok;
    logic [aap_pkg::EXT_PA_W-1:0]      phys;
    logic                              idle_cmd;

    aap_pt_if pt ();

    aap_page_table #(.ADDR_W(aap_pkg::PT_ADDR_W), .DATA_W(aap_pkg::PT_DATA_W)) u_pt (.clk_in(sys_clk_in), .pt(pt));

    // Reset release through two flops
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Mode bits and operand selection
    assign m_x       = held_q[aap_pkg::MODE_X_BIT];
    assign m_i       = held_q[aap_pkg::MODE_I_BIT];
    assign m_b       = held_q[aap_pkg::MODE_B_BIT];
    assign disp_ext  = {{(aap_pkg::VA_W-aap_pkg::DISP_W){held_q[aap_pkg::SIGN_BIT]}},
                        held_q[aap_pkg::DISP_W-1:0]};
    // Counter is already past the instruction, hence the step back
    assign base_val  = m_b ? b_reg_in : pc_q - aap_pkg::PC_STEP;
    assign x_off     = m_x ? x_reg_in : aap_pkg::WORD_ZERO;
    assign pre_sum   = base_val + disp_ext;
    assign direct_ea = ((m_x && !m_b) ? disp_ext : pre_sum) + x_off;
    assign idle_cmd  = (st_q == S_IDLE);

    // Page table access
    assign pt.wr_en   = pt_wr_in;
    assign pt.wr_addr = {pt_wr_tab_in, pt_wr_vpn_in};
    assign pt.wr_data = {pt_wr_prot_in, pt_wr_map_in};
    assign pt.rd_addr = {pt_sel_in, va_q[aap_pkg::VA_W-1:aap_pkg::PAGE_OFF_W]};

    assign prot      = pt.rd_data[aap_pkg::PT_DATA_W-1:aap_pkg::EXT_PPN_W];
    assign ppn       = pt.rd_data[aap_pkg::EXT_PPN_W-1:0];
    assign page_ring = prot[aap_pkg::PROT_RING_LSB +: aap_pkg::RING_W];

    always_comb begin
        case (use_q)
            U_FETCH, U_PREF: acc_kind = aap_pkg::AAP_ACC_FETCH;
            U_OPND:          acc_kind = op_write_in ? aap_pkg::AAP_ACC_WRITE : aap_pkg::AAP_ACC_READ;
            default:         acc_kind = aap_pkg::AAP_ACC_READ;
        endcase
        case (acc_kind)
            aap_pkg::AAP_ACC_FETCH: permit_ok = prot[aap_pkg::PROT_FETCH_B];
            aap_pkg::AAP_ACC_WRITE: permit_ok = prot[aap_pkg::PROT_WRITE_B];
            default:                permit_ok = prot[aap_pkg::PROT_READ_B];
        endcase
    end

    assign ring_ok = (user_ring_in >= page_ring);
    // Same translation for data and instruction pages
    assign phys = ext_mode_in ?
                  {ppn, va_q[aap_pkg::PAGE_OFF_W-1:0]} :
                  {{(aap_pkg::EXT_PA_W-aap_pkg::NORM_PA_W){1'b0}},
                   ppn[aap_pkg::NORM_PPN_W-1:0], va_q[aap_pkg::PAGE_OFF_W-1:0]};

    // Sequencer; commands only taken when idle
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= S_IDLE;
            use_q <= U_FETCH;
            va_q  <= aap_pkg::WORD_ZERO;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (cmd_in == aap_pkg::AAP_CMD_FETCH) begin
                        st_q  <= S_LOOK;
                        use_q <= U_FETCH;
                        va_q  <= pc_q;
                    end else if (cmd_in == aap_pkg::AAP_CMD_START && pf_valid_q) begin
                        st_q  <= S_LOOK;
                        use_q <= U_PREF;
                        va_q  <= pc_q + aap_pkg::PC_STEP;
                    end else if (cmd_in == aap_pkg::AAP_CMD_EA) begin
                        st_q  <= S_LOOK;
                        use_q <= m_i ? U_PTR : U_OPND;
                        va_q  <= m_i ? pre_sum : direct_ea;
                    end
                end
                S_LOOK: st_q <= S_CHK;
                S_CHK: begin
                    if (!permit_ok || !ring_ok || use_q == U_OPND) begin
                        st_q <= S_IDLE;
                    end else begin
                        st_q <= S_BUS;
                    end
                end
                S_BUS: begin
                    if (mem_ack_in) begin
                        case (use_q)
                            U_FETCH: begin
                                st_q  <= S_LOOK;
                                use_q <= U_PREF;
                                va_q  <= pc_q;
                            end
                            U_PTR:   st_q <= S_POST;
                            default: st_q <= S_IDLE;
                        endcase
                    end
                end
                S_POST: begin
                    st_q  <= S_LOOK;
                    use_q <= U_OPND;
                    va_q  <= ind_latch_q + x_off;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Counter points at the prefetched word, so counter minus one is the running word
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= aap_pkg::PC_RESET;
        end else if (idle_cmd && pc_load_in) begin
            pc_q <= pc_new_in;
        end else if (idle_cmd && (cmd_in == aap_pkg::AAP_CMD_FETCH ||
                     (cmd_in == aap_pkg::AAP_CMD_START && pf_valid_q))) begin
            pc_q <= pc_q + aap_pkg::PC_STEP;
        end
    end

    // Instruction words
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            held_q     <= aap_pkg::WORD_ZERO;
            pf_word_q  <= aap_pkg::WORD_ZERO;
            pf_valid_q <= 1'b0;
        end else if (idle_cmd && pc_load_in) begin
            pf_valid_q <= 1'b0;
        end else if (idle_cmd && cmd_in == aap_pkg::AAP_CMD_FETCH) begin
            pf_valid_q <= 1'b0;
        end else if (idle_cmd && cmd_in == aap_pkg::AAP_CMD_START && pf_valid_q) begin
            held_q     <= pf_word_q;
            pf_valid_q <= 1'b0;
        end else if (st_q == S_BUS && mem_ack_in && use_q == U_FETCH) begin
            held_q     <= mem_rdata_in;
        end else if (st_q == S_BUS && mem_ack_in && use_q == U_PREF) begin
            pf_word_q  <= mem_rdata_in;
            pf_valid_q <= 1'b1;
        end
    end

    // Indirect latch
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ind_latch_q <= aap_pkg::WORD_ZERO;
        end else if (st_q == S_BUS && mem_ack_in && use_q == U_PTR) begin
            ind_latch_q <= mem_rdata_in;
        end
    end

    // Memory request held until acknowledged
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_q   <= 1'b0;
            mem_kind_q  <= aap_pkg::AAP_ACC_READ;
            mem_paddr_q <= {aap_pkg::EXT_PA_W{1'b0}};
        end else if (st_q == S_CHK && permit_ok && ring_ok && use_q != U_OPND) begin
            mem_req_q   <= 1'b1;
            mem_kind_q  <= acc_kind;
            mem_paddr_q <= phys;
        end else if (st_q == S_BUS && mem_ack_in) begin
            mem_req_q   <= 1'b0;
        end
    end

    // Result and fault pulses
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ea_q       <= aap_pkg::WORD_ZERO;
            ea_paddr_q <= {aap_pkg::EXT_PA_W{1'b0}};
            ea_valid_q <= 1'b0;
            fault_q    <= 1'b0;
        end else begin
            ea_valid_q <= 1'b0;
            fault_q    <= 1'b0;
            if (st_q == S_CHK) begin
                if (!permit_ok || !ring_ok) begin
                    fault_q <= 1'b1;
                end else if (use_q == U_OPND) begin
                    ea_q       <= va_q;
                    ea_paddr_q <= phys;
                    ea_valid_q <= 1'b1;
                end
            end
        end
    end

    assign mem_req_out                     = mem_req_q;
    assign mem_kind_out                    = mem_kind_q;
    assign mem_paddr_out                   = mem_paddr_q;
    assign pc_out                          = pc_q;
    assign held_instruction_word_out       = held_q;
    assign prefetched_instruction_word_out = pf_word_q;
    assign pf_valid_out                    = pf_valid_q;
    assign indirect_read_latch_out         = ind_latch_q;
    assign ea_out                          = ea_q;
    assign ea_paddr_out                    = ea_paddr_q;
    assign ea_valid_out                    = ea_valid_q;
    assign fault_out                       = fault_q;
    assign busy_out                        = !idle_cmd;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n);

    property p_fetch_inc;
        idle_cmd && cmd_in == aap_pkg::AAP_CMD_FETCH && !pc_load_in |=>
            pc_q == $past(pc_q) + aap_pkg::PC_STEP && va_q == $past(pc_q) && use_q == U_FETCH;
    endproperty
    a_fetch_inc: assert property (p_fetch_inc) else $error("fetch did not use and bump counter");
    property p_fetch_then_pref;
        st_q == S_BUS && use_q == U_FETCH && mem_ack_in |=>
            st_q == S_LOOK && use_q == U_PREF && va_q == $past(pc_q) && pc_q == $past(pc_q) ##1 st_q == S_CHK;
    endproperty
    a_fetch_then_pref: assert property (p_fetch_then_pref) else $error("no prefetch after fetch");
    property p_start_pref;
        idle_cmd && cmd_in == aap_pkg::AAP_CMD_START && pf_valid_q && !pc_load_in |=>
            held_q == $past(pf_word_q) && !pf_valid_q && use_q == U_PREF &&
            va_q == $past(pc_q) + aap_pkg::PC_STEP;
    endproperty
    a_start_pref: assert property (p_start_pref) else $error("start did not launch prefetch");
    property p_pc_rel;
        idle_cmd && cmd_in == aap_pkg::AAP_CMD_EA && !m_x && !m_i && !m_b |=>
            va_q == $past(pc_q) - 16'h0001 +
                    {{8{$past(held_q[7])}}, $past(held_q[7:0])};
    endproperty
    a_pc_rel: assert property (p_pc_rel) else $error("counter relative address wrong");
    property p_ind_first;
        idle_cmd && cmd_in == aap_pkg::AAP_CMD_EA && m_i && m_b |=>
            use_q == U_PTR && va_q == $past(b_reg_in) + $past(disp_ext);
    endproperty
    a_ind_first: assert property (p_ind_first) else $error("indirect pointer address wrong");
    property p_latch;
        st_q == S_BUS && use_q == U_PTR && mem_ack_in |=>
            ind_latch_q == $past(mem_rdata_in) && st_q == S_POST;
    endproperty
    a_latch: assert property (p_latch) else $error("indirect latch not loaded");
    property p_post;
        st_q == S_POST |=> va_q == $past(ind_latch_q) + $past(x_off) && use_q == U_OPND;
    endproperty
    a_post: assert property (p_post) else $error("post index sum wrong");
    property p_ring;
        st_q == S_CHK && user_ring_in < page_ring |=> fault_q && !mem_req_q && st_q == S_IDLE;
    endproperty
    a_ring: assert property (p_ring) else $error("ring violation not refused");
    property p_fetch_perm;
        st_q == S_CHK && use_q != U_PTR && use_q != U_OPND && !prot[aap_pkg::PROT_FETCH_B] |=> fault_q;
    endproperty
    a_fetch_perm: assert property (p_fetch_perm) else $error("fetch permit ignored");
    property p_norm_pa;
        $rose(mem_req_q) && !$past(ext_mode_in) |->
            mem_paddr_q[23:19] == 5'h00 && mem_paddr_q[9:0] == va_q[9:0];
    endproperty
    a_norm_pa: assert property (p_norm_pa) else $error("normal mode address too wide");
    c_fetch_pair: cover property (st_q == S_BUS && use_q == U_PREF && mem_ack_in);
    c_indirect:   cover property (st_q == S_POST ##2 ea_valid_q);
    c_fault:      cover property (fault_q);
endmodule

// >>> verification/aap_mem_model.sv
`timescale 1ns/100ps
module aap_mem_model (
    // Bus side
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic [23:0] paddr_in,
    input  wire logic        slow_in,
    output logic             ack_out,
    output logic [15:0]      rdata_out
);
    logic        ack_q = 1'b0;
    logic [1:0]  wait_q = 2'h0;
    logic [15:0] last_q = 16'h0000;
    assign ack_out = ack_q;
    // Stale data inverted so a late capture cannot pass by luck
    assign rdata_out = ack_q ? (paddr_in[15:0] ^ 16'h5A5A) : ~last_q;
    always @(posedge clk_in) begin
        ack_q <= 1'b0;
        if (ack_q) last_q <= rdata_out;
        if (req_in && !ack_q) begin
            wait_q <= wait_q + 2'h1;
            if (!slow_in || wait_q == 2'h3) begin
                ack_q  <= 1'b1;
                wait_q <= 2'h0;
            end
        end
    end
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
    typedef struct packed {logic [15:0] w, x, b; logic ext; logic [1:0] sel;} aap_row_t;
    logic clk = 1'b0, rst_n = 1'b0, opw = 1'b0, pcl = 1'b0, ext = 1'b0, slow = 1'b0, ptw = 1'b0;
    logic [15:0] pcn = 16'h0000, xr = 16'h0000, br = 16'h0000, pc, ea, hw, pw, lat, rdata, p0, va, pt;
    logic [1:0] sel = 2'h0, ring = 2'h0, tab = 2'h0;
    logic [5:0] vpn = 6'h00;
    logic [6:0] prot = 7'h00;
    logic [13:0] map = 14'h0000;
    logic req, ack, pfv, eav, flt, busy, s_ea, s_f;
    logic [23:0] pa, eapa;
    aap_pkg::aap_acc_t kind, kd;
    aap_pkg::aap_cmd_t cmd = aap_pkg::AAP_CMD_NONE;
    int failures = 0, compares = 0;
    aap_row_t rows [8] = '{'{16'h0005, 16'h0000, 16'h0000, 1'b0, 2'h0}, '{16'h02F0, 16'h1111, 16'h0000, 1'b1, 2'h1},
        '{16'h017F, 16'h0000, 16'hFFF0, 1'b0, 2'h2}, '{16'h0380, 16'h0000, 16'h2000, 1'b1, 2'h3},
        '{16'h0410, 16'h4321, 16'h0000, 1'b0, 2'h0}, '{16'h0581, 16'h0100, 16'hFFFF, 1'b1, 2'h1},
        '{16'h0602, 16'h0010, 16'h0000, 1'b0, 2'h2}, '{16'h07FF, 16'h8000, 16'h1234, 1'b1, 2'h3}};
    aap_core i_aap_core (.sys_clk_in(clk), .arst_n_in(rst_n), .cmd_in(cmd), .op_write_in(opw), .pc_load_in(pcl),
        .pc_new_in(pcn), .x_reg_in(xr), .b_reg_in(br), .mem_req_out(req), .mem_kind_out(kind), .mem_paddr_out(pa),
        .mem_ack_in(ack), .mem_rdata_in(rdata), .ext_mode_in(ext), .pt_sel_in(sel), .user_ring_in(ring),
        .pt_wr_in(ptw), .pt_wr_tab_in(tab), .pt_wr_vpn_in(vpn), .pt_wr_prot_in(prot), .pt_wr_map_in(map),
        .pc_out(pc), .held_instruction_word_out(hw), .prefetched_instruction_word_out(pw), .pf_valid_out(pfv),
        .indirect_read_latch_out(lat), .ea_out(ea), .ea_paddr_out(eapa), .ea_valid_out(eav), .fault_out(flt),
        .busy_out(busy));
    aap_mem_model i_aap_mem_model (.clk_in(clk), .req_in(req), .paddr_in(pa), .slow_in(slow), .ack_out(ack),
        .rdata_out(rdata));
    initial forever #4 clk = ~clk;
    function automatic logic [13:0] map_of(input logic [1:0] t, input logic [5:0] v);
        return {6'h2B, t, v ^ 6'h2A};
    endfunction
    function automatic logic [23:0] pa_of(input logic [15:0] v);
        logic [13:0] m;
        m = map_of(sel, v[15:10]);
        return ext ? {m, v[9:0]} : {5'h00, m[8:0], v[9:0]};
    endfunction
    // Map flips page bits by 2A, model flips data by 5A5A
    function automatic logic [15:0] word_of(input logic [15:0] v);
        return v ^ 16'hF25A;
    endfunction
    task automatic complete_run();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input aap_pkg::aap_cmd_t c);
        @(posedge clk) cmd <= c;
        @(posedge clk) cmd <= aap_pkg::AAP_CMD_NONE;
    endtask
    task automatic done();
        int n;
        n = 0;
        s_ea = 1'b0;
        s_f = 1'b0;
        do begin
            @(posedge clk) #1;
            s_ea |= eav;
            s_f |= flt;
            if (req === 1'b1) kd = kind;
            n++;
        end while (busy !== 1'b0 && n < 300);
        if (busy !== 1'b0) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic ld(input logic [1:0] t, input logic [5:0] v, input logic [6:0] p);
        @(posedge clk) {ptw, tab, vpn, prot, map} <= {1'b1, t, v, p, map_of(t, v)};
        @(posedge clk) ptw <= 1'b0;
    endtask
    task automatic pcload(input logic [15:0] v);
        @(posedge clk) {pcl, pcn} <= {1'b1, v};
        @(posedge clk) pcl <= 1'b0;
        #1 chk(pc, v);
        chk(pfv, 1'b0);
    endtask
    task automatic fetch(input logic [15:0] v);
        pcload(v);
        step(aap_pkg::AAP_CMD_FETCH);
        done();
        chk(hw, word_of(v));
        chk(pw, word_of(v + 16'h0001));
        chk(pc, v + 16'h0001);
        chk(kd, aap_pkg::AAP_ACC_FETCH);
        chk(pfv, 1'b1);
    endtask
    task automatic flt_case(input logic [6:0] p, input logic [1:0] r, input logic [15:0] w, input logic o, f, e);
        ld(sel, 6'h20, p);
        {ring, opw, br} <= {r, o, 16'h8000};
        if (f) pcload(16'h8000);
        else fetch(w ^ 16'hF25A);
        step(f ? aap_pkg::AAP_CMD_FETCH : aap_pkg::AAP_CMD_EA);
        done();
        chk(s_f, e);
        chk(s_ea, !e && !f);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({pc, busy, req}, 24'h000000);
        for (int t = 0; t < 4; t++) for (int v = 0; v < 64; v++) ld(t[1:0], v[5:0], 7'h70);
        foreach (rows[i]) begin
            @(posedge clk) {ext, sel, xr, br, slow} <= {rows[i].ext, rows[i].sel, rows[i].x, rows[i].b, i[0]};
            p0 = rows[i].w ^ 16'hF25A;
            fetch(p0);
            step(aap_pkg::AAP_CMD_EA);
            done();
            va = {{8{rows[i].w[7]}}, rows[i].w[7:0]} + (rows[i].w[10] ? rows[i].x : 16'h0000);
            pt = (rows[i].w[8] ? rows[i].b : p0) + {{8{rows[i].w[7]}}, rows[i].w[7:0]};
            if (rows[i].w[9]) va = word_of(pt) + (rows[i].w[10] ? rows[i].x : 16'h0000);
            else if (rows[i].w[8] || !rows[i].w[10]) va = va + (rows[i].w[8] ? rows[i].b : p0);
            chk(s_ea, 1'b1);
            chk(ea, va);
            chk(eapa, pa_of(va));
            if (rows[i].w[9]) chk(lat, word_of(pt));
            if (rows[i].w[9]) chk(kd, aap_pkg::AAP_ACC_READ);
        end
        step(aap_pkg::AAP_CMD_START);
        done();
        chk(hw, word_of(p0 + 16'h0001));
        chk(pw, word_of(p0 + 16'h0002));
        chk(pc, p0 + 16'h0002);
        pcload(16'h0100);
        step(aap_pkg::AAP_CMD_START);
        done();
        chk(pc, 16'h0100);
        flt_case(7'h50, 2'h0, 16'h0300, 1'b0, 1'b0, 1'b1);
        flt_case(7'h30, 2'h0, 16'h0100, 1'b1, 1'b0, 1'b1);
        flt_case(7'h30, 2'h0, 16'h0100, 1'b0, 1'b0, 1'b0);
        flt_case(7'h60, 2'h0, 16'h0100, 1'b0, 1'b1, 1'b1);
        flt_case(7'h72, 2'h1, 16'h0100, 1'b0, 1'b0, 1'b1);
        flt_case(7'h72, 2'h2, 16'h0100, 1'b0, 1'b0, 1'b0);
        flt_case(7'h72, 2'h3, 16'h0100, 1'b0, 1'b0, 1'b0);
        complete_run();
    end
endmodule
